// *** bench/mag_data_status_readout_tb.sv ***
// Self-checking bench for the magnetic readout block
`timescale 1ns/1ps

module mag_data_status_readout_tb;
  import mds_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        go = 1'b0;
  logic [1:0]  go_axis = 2'h0;
  logic [15:0] go_mag = 16'h0000;
  logic        samp_valid;
  logic [1:0]  samp_axis;
  logic [15:0] samp_mag;
  logic        samp_ready;
  logic        acc_valid = 1'b0;
  logic [13:0] acc_x = 14'h0000;
  logic [13:0] acc_y = 14'h0000;
  logic [2:0]  rate_sel = 3'h0;
  logic [2:0]  os_sel = 3'h0;
  logic        rd_en = 1'b0;
  logic [7:0]  rd_addr = 8'h00;
  logic [7:0]  rd_data;
  logic        rd_valid;
  int          err_count = 0;
  int          checks = 0;

  // ========================================================
  // Clock, design and sample source
  always #4 sys_clk = ~sys_clk;

  mds_readout mds_readout_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .samp_valid(samp_valid),
    .samp_axis(samp_axis), .samp_mag(samp_mag),
    .samp_ready(samp_ready), .acc_valid(acc_valid), .acc_x(acc_x),
    .acc_y(acc_y), .output_rate_select(rate_sel),
    .mag_oversample_select(os_sel), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  mds_src_model mds_src_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .go(go), .go_axis(go_axis),
    .go_mag(go_mag), .samp_ready(samp_ready),
    .samp_valid(samp_valid), .samp_axis(samp_axis),
    .samp_mag(samp_mag)
  );

  // ========================================================
  // Shared tasks
  task automatic finish_test();
    $display("Errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %02h exp %02h", $time, got, exp);
    end
  endtask

  // One read, answer judged while the one-cycle rd_valid stands
  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge sys_clk);
    rd_en = 1'b1;
    rd_addr = addr;
    @(negedge sys_clk);
    rd_en = 1'b0;
    expect8({7'h00, rd_valid}, 8'h01);
    expect8(rd_data, exp);
  endtask

  // Bounded wait until the offered word is taken
  task automatic wait_taken();
    int n;
    n = 0;
    while (samp_valid && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (samp_valid) begin
      err_count++;
      $display("BAD t=%0t wait %02h %02h", $time, n, 60);
      finish_test();
    end
  endtask

  task automatic send(input logic [1:0] axis, input logic [15:0] val);
    @(negedge sys_clk);
    go = 1'b1;
    go_axis = axis;
    go_mag = val;
    @(negedge sys_clk);
    go = 1'b0;
    wait_taken();
  endtask

  // Idle cycles let the FIFO drain into the registers
  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask

  // ========================================================
  // Scenarios
  task automatic scen_reset();
    reg_read(ADDR_STATUS, 8'h00);
    reg_read(ADDR_X_HI, 8'h00);
    reg_read(ADDR_Z_LO, 8'h00);
    reg_read(8'h40, 8'h00);
  endtask

  // Ready flags set per axis, cleared by high reads only
  task automatic scen_ready();
    send(2'd0, 16'h8123);
    send(2'd1, 16'h7F0A);
    send(2'd2, 16'hC3B5);
    settle();
    reg_read(ADDR_STATUS, 8'h0F);
    reg_read(ADDR_X_HI, 8'h81);
    reg_read(ADDR_STATUS, 8'h0E);
    reg_read(ADDR_X_LO, 8'h23);
    reg_read(ADDR_Y_LO, 8'h0A);
    reg_read(ADDR_Y_HI, 8'h7F);
    reg_read(ADDR_STATUS, 8'h0C);
    reg_read(ADDR_Z_LO, 8'hB5);
    reg_read(ADDR_STATUS, 8'h0C);
    reg_read(ADDR_Z_HI, 8'hC3);
    reg_read(ADDR_STATUS, 8'h00);
  endtask

  // Unread samples replaced set the overwrite flags
  task automatic scen_over();
    send(2'd0, 16'h1111);
    send(2'd0, 16'h2233);
    settle();
    reg_read(ADDR_STATUS, 8'h11);
    reg_read(ADDR_X_LO, 8'h33);
    send(2'd1, 16'h4444);
    send(2'd1, 16'h5555);
    send(2'd2, 16'h6666);
    send(2'd2, 16'h7777);
    settle();
    reg_read(ADDR_STATUS, 8'h7F);
    send(2'd0, 16'h0102);
    send(2'd1, 16'h0304);
    send(2'd2, 16'h0506);
    settle();
    reg_read(ADDR_STATUS, 8'hFF);
    reg_read(ADDR_X_HI, 8'h01);
    reg_read(ADDR_STATUS, 8'hEE);
    reg_read(ADDR_Z_HI, 8'h05);
    reg_read(ADDR_STATUS, 8'hAA);
    reg_read(ADDR_Y_HI, 8'h03);
    reg_read(ADDR_STATUS, 8'h00);
  endtask

  // Reads stall the drain, so the FIFO fills and refuses
  task automatic scen_fill();
    int k;
    @(negedge sys_clk);
    rd_en = 1'b1;
    rd_addr = 8'h40;
    for (k = 0; k < FIFO_DEPTH; k++) begin
      send(2'd0, 16'hA000 + 16'(k));
    end
    @(negedge sys_clk);
    go = 1'b1;
    go_mag = 16'hBEEF;
    @(negedge sys_clk);
    go = 1'b0;
    repeat (10) @(negedge sys_clk);
    expect8({6'h00, samp_valid, samp_ready}, 8'h02);
    rd_en = 1'b0;
    wait_taken();
    settle();
    reg_read(ADDR_STATUS, 8'h11);
    reg_read(ADDR_X_LO, 8'hEF);
    reg_read(ADDR_X_HI, 8'hBE);
  endtask

  // Aligned acceleration, right-justified, top bits zero
  task automatic scen_accel();
    @(negedge sys_clk);
    acc_valid = 1'b1;
    acc_x = 14'h3A5C;
    acc_y = 14'h1C3E;
    @(negedge sys_clk);
    acc_valid = 1'b0;
    send(2'd0, 16'h0F0F);
    send(2'd1, 16'hF0F0);
    settle();
    reg_read(ADDR_ACC_X_HI, 8'h3A);
    reg_read(ADDR_ACC_X_LO, 8'h5C);
    reg_read(ADDR_ACC_Y_HI, 8'h1C);
    reg_read(ADDR_ACC_Y_LO, 8'h3E);
    reg_read(8'h3D, 8'h00);
  endtask

  // Both selects at one give a ratio of four; only the 4th is kept
  task automatic scen_decim();
    int k;
    @(negedge sys_clk);
    rate_sel = 3'h1;
    os_sel = 3'h1;
    for (k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      acc_valid = 1'b1;
      acc_x = 14'h2AB8 + 14'(k);
      @(negedge sys_clk);
      acc_valid = 1'b0;
    end
    send(2'd0, 16'h1234);
    settle();
    reg_read(ADDR_ACC_X_HI, 8'h2A);
    reg_read(ADDR_ACC_X_LO, 8'hBB);
    rate_sel = 3'h0;
    os_sel = 3'h0;
  endtask

  // ========================================================
  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    scen_reset();
    scen_ready();
    scen_over();
    scen_fill();
    scen_accel();
    scen_decim();
    finish_test();
  end
endmodule

// *** bench/mds_src_model.sv ***
// Sample source model offering magnetic words over valid/ready
`timescale 1ns/1ps

module mds_src_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [1:0]  go_axis,
  input  wire logic [15:0] go_mag,
  input  wire logic        samp_ready,
  output logic             samp_valid,
  output logic [1:0]       samp_axis,
  output logic [15:0]      samp_mag
);
  // ========================================================
  // Offer held until taken, then the word is scrambled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_valid <= 1'b0;
      samp_axis  <= 2'h3;
      samp_mag   <= 16'h0000;
    end else if (samp_valid && samp_ready) begin
      samp_valid <= 1'b0;
      samp_mag   <= ~samp_mag; // Stale word must not look usable
    end else if (go && !samp_valid) begin
      samp_valid <= 1'b1;
      samp_axis  <= go_axis;
      samp_mag   <= go_mag;
    end
  end
endmodule

// *** verilog/mds_pkg.sv ***
// Shared constants for the magnetic data status readout block
package mds_pkg;

  // ==========================================================
  // Register addresses on the serial register port
  localparam logic [7:0] ADDR_STATUS   = 8'h32;
  localparam logic [7:0] ADDR_X_HI     = 8'h33;
  localparam logic [7:0] ADDR_X_LO     = 8'h34;
  localparam logic [7:0] ADDR_Y_HI     = 8'h35;
  localparam logic [7:0] ADDR_Y_LO     = 8'h36;
  localparam logic [7:0] ADDR_Z_HI     = 8'h37;
  localparam logic [7:0] ADDR_Z_LO     = 8'h38;
  localparam logic [7:0] ADDR_ACC_X_HI = 8'h39;
  localparam logic [7:0] ADDR_ACC_X_LO = 8'h3A;
  localparam logic [7:0] ADDR_ACC_Y_HI = 8'h3B;
  localparam logic [7:0] ADDR_ACC_Y_LO = 8'h3C;
  localparam logic [7:0] AXIS_STRIDE   = 8'h02;

  // ==========================================================
  // Status register bit positions
  localparam int BIT_XDR   = 0;
  localparam int BIT_YDR   = 1;
  localparam int BIT_ZDR   = 2;
  localparam int BIT_XYZDR = 3;
  localparam int BIT_XOW   = 4;
  localparam int BIT_YOW   = 5;
  localparam int BIT_ZOW   = 6;
  localparam int BIT_XYZOW = 7;

  // ==========================================================
  // Reset values and widths
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] OUT_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam int         MAG_W        = 16;
  localparam int         ACC_W        = 14;
  localparam int         NUM_AXES     = 3;
  localparam int         FIFO_DEPTH   = 4;
  localparam int         DEC_W        = 16;

  // ==========================================================
  // Axis codes carried with each magnetic sample
  typedef enum logic [1:0] {
    MDS_AXIS_X,
    MDS_AXIS_Y,
    MDS_AXIS_Z,
    MDS_AXIS_NONE
  } mds_axis_e;

endpackage

// *** verilog/mds_readout.sv ***
// Magnetic data status, output and aligned acceleration readout
`timescale 1ns/1ps

// ============================================================

// ============================================================
// Sample FIFO
module mds_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  // Storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ============================================================
// Readout top
module mds_readout #(
  parameter int FIFO_DEPTH = mds_pkg::FIFO_DEPTH
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       samp_valid,
  input  wire logic [1:0]                 samp_axis,
  input  wire logic [mds_pkg::MAG_W-1:0]  samp_mag,
  output logic                            samp_ready,
  input  wire logic                       acc_valid,
  input  wire logic [mds_pkg::ACC_W-1:0]  acc_x,
  input  wire logic [mds_pkg::ACC_W-1:0]  acc_y,
  input  wire logic [2:0]                 output_rate_select,
  input  wire logic [2:0]                 mag_oversample_select,
  input  wire logic                       rd_en,
  input  wire logic [7:0]                 rd_addr,
  output logic [7:0]                      rd_data,
  output logic                            rd_valid
);
  import mds_pkg::*;

  localparam int FW = 2 + MAG_W;

  logic [FW-1:0]    f_in;
  logic [FW-1:0]    f_data;
  logic             f_valid;
  logic             f_ready;
  logic             f_in_ready;
  logic             samp_ready_q;
  logic [2:0]       land_v;
  logic [2:0]       rdhi_v;
  logic [2:0]       dr_q;
  logic [2:0]       ow_q;
  logic [MAG_W-1:0] mag_q [NUM_AXES];
  logic [2:0]       seen_q;
  logic [2:0]       rdseen_q;
  logic             set_done;
  logic             all_read;
  logic             xyzdr_q;
  logic             xyzow_q;
  logic [7:0]       status;
  logic [DEC_W-1:0] dec_cnt_q;
  logic [DEC_W-1:0] dec_lim;
  logic [3:0]       dec_exp;
  logic [ACC_W-1:0] acc_dec_x_q;
  logic [ACC_W-1:0] acc_dec_y_q;
  logic [ACC_W-1:0] acc_al_x_q;
  logic [ACC_W-1:0] acc_al_y_q;
  logic [7:0]       rd_data_q;
  logic             rd_valid_q;

  // ==========================================================
  // Buffering; drain stalls on reads so set and clear never meet
  assign f_in    = {samp_axis, samp_mag};
  assign f_ready = !rd_en;

  mds_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (samp_valid && samp_ready_q),
    .in_data   (f_in),
    .in_ready  (f_in_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // Registered ready; lags one cycle behind the fill count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_ready_q <= 1'b0;
    end else begin
      samp_ready_q <= f_in_ready && !(samp_valid && samp_ready_q);
    end
  end
  assign samp_ready = samp_ready_q;

  // ==========================================================
  // Per-axis landing, high-byte reads, flags and data
  generate
    for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
      assign land_v[i] = f_valid && f_ready
                         && (f_data[FW-1:MAG_W] == 2'(i));
      assign rdhi_v[i] = rd_en
                         && (rd_addr == ADDR_X_HI + 8'(i) * AXIS_STRIDE);

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mag_q[i] <= {OUT_RST, OUT_RST};
        end else if (land_v[i]) begin
          mag_q[i] <= f_data[MAG_W-1:0];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dr_q[i] <= 1'b0;
        end else if (land_v[i]) begin
          dr_q[i] <= 1'b1;
        end else if (rdhi_v[i]) begin
          dr_q[i] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ow_q[i] <= 1'b0;
        end else if (land_v[i] && dr_q[i]) begin
          ow_q[i] <= 1'b1;
        end else if (rdhi_v[i]) begin
          ow_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Combined set tracking
  assign set_done = (|land_v) && ((seen_q | land_v) == 3'h7);
  assign all_read = (|rdhi_v) && ((rdseen_q | rdhi_v) == 3'h7);

  // Axes landed and high bytes read since last set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q   <= '0;
      rdseen_q <= '0;
    end else begin
      seen_q   <= set_done ? 3'h0 : (seen_q | land_v);
      rdseen_q <= all_read ? 3'h0 : (rdseen_q | rdhi_v);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xyzdr_q <= 1'b0;
    end else if (set_done) begin
      xyzdr_q <= 1'b1;
    end else if (all_read) begin
      xyzdr_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xyzow_q <= 1'b0;
    end else if (set_done && xyzdr_q) begin
      xyzow_q <= 1'b1;
    end else if (all_read) begin
      xyzow_q <= 1'b0;
    end
  end

  always_comb begin
    status            = STATUS_RST;
    status[BIT_XDR]   = dr_q[0];
    status[BIT_YDR]   = dr_q[1];
    status[BIT_ZDR]   = dr_q[2];
    status[BIT_XYZDR] = xyzdr_q;
    status[BIT_XOW]   = ow_q[0];
    status[BIT_YOW]   = ow_q[1];
    status[BIT_ZOW]   = ow_q[2];
    status[BIT_XYZOW] = xyzow_q;
  end

  // ==========================================================
  // Decimation; power-of-two ratio keeps the divider a shift
  assign dec_exp = 4'({1'b0, mag_oversample_select})
                   + 4'({1'b0, output_rate_select});
  assign dec_lim = (DEC_W'(1) << dec_exp) - DEC_W'(1);

  // Keep one of every ratio samples
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_q   <= '0;
      acc_dec_x_q <= '0;
      acc_dec_y_q <= '0;
    end else if (acc_valid) begin
      if (dec_cnt_q >= dec_lim) begin
        dec_cnt_q   <= '0;
        acc_dec_x_q <= acc_x;
        acc_dec_y_q <= acc_y;
      end else begin
        dec_cnt_q <= dec_cnt_q + 1'b1;
      end
    end
  end

  // Align with the magnetic sample landing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_al_x_q <= '0;
      acc_al_y_q <= '0;
    end else begin
      if (land_v[0]) begin
        acc_al_x_q <= acc_dec_x_q;
      end
      if (land_v[1]) begin
        acc_al_y_q <= acc_dec_y_q;
      end
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  // Right-justified acceleration bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q  <= UNMAPPED_VAL;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (!rd_en) begin
        rd_data_q <= rd_data_q;
      end else if (rd_addr == ADDR_STATUS) begin
        rd_data_q <= status;
      end else if (rd_addr == ADDR_X_HI) begin
        rd_data_q <= mag_q[0][15:8];
      end else if (rd_addr == ADDR_X_LO) begin
        rd_data_q <= mag_q[0][7:0];
      end else if (rd_addr == ADDR_Y_HI) begin
        rd_data_q <= mag_q[1][15:8];
      end else if (rd_addr == ADDR_Y_LO) begin
        rd_data_q <= mag_q[1][7:0];
      end else if (rd_addr == ADDR_Z_HI) begin
        rd_data_q <= mag_q[2][15:8];
      end else if (rd_addr == ADDR_Z_LO) begin
        rd_data_q <= mag_q[2][7:0];
      end else if (rd_addr == ADDR_ACC_X_HI) begin
        rd_data_q <= {2'b00, acc_al_x_q[13:8]};
      end else if (rd_addr == ADDR_ACC_X_LO) begin
        rd_data_q <= acc_al_x_q[7:0];
      end else if (rd_addr == ADDR_ACC_Y_HI) begin
        rd_data_q <= {2'b00, acc_al_y_q[13:8]};
      end else if (rd_addr == ADDR_ACC_Y_LO) begin
        rd_data_q <= acc_al_y_q[7:0];
      end else begin
        rd_data_q <= UNMAPPED_VAL;
      end
    end
  end
  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_x_ready_set: assert property (
    land_v[0] |=> dr_q[0] ##1 (dr_q[0] || $past(rdhi_v[0])))
    else $error("x ready not set on landing");
  chk_y_ready_clear: assert property (
    rdhi_v[1] |=> !dr_q[1])
    else $error("y ready not cleared by high read");
  chk_z_ready_set: assert property (
    land_v[2] |=> dr_q[2] && status[BIT_ZDR])
    else $error("z ready not set on landing");
  chk_x_over_set: assert property (
    land_v[0] && dr_q[0] |=> ow_q[0])
    else $error("x overwrite missed");
  chk_y_over_clear: assert property (
    rdhi_v[1] |=> !ow_q[1] && !dr_q[1])
    else $error("y overwrite not cleared");
  chk_z_over_quiet: assert property (
    land_v[2] && !dr_q[2] && !ow_q[2] |=> !ow_q[2])
    else $error("z overwrite set without unread data");
  chk_set_ready: assert property (
    set_done |=> xyzdr_q && seen_q == 3'h0)
    else $error("combined ready not set");
  chk_set_ready_clear: assert property (
    all_read && !set_done |=> !xyzdr_q)
    else $error("combined ready not cleared");
  chk_set_over: assert property (
    set_done && xyzdr_q |=> xyzow_q)
    else $error("combined overwrite missed");
  chk_set_over_hold: assert property (
    xyzow_q && !all_read |=> xyzow_q)
    else $error("combined overwrite cleared early");
  chk_status_read: assert property (
    rd_en && rd_addr == ADDR_STATUS
    |=> rd_valid && rd_data == $past(status))
    else $error("status read wrong");
  chk_accel_just: assert property (
    rd_en && (rd_addr == ADDR_ACC_X_HI || rd_addr == ADDR_ACC_Y_HI)
    |=> rd_data[7:6] == 2'b00)
    else $error("accel high byte not right-justified");
  chk_mag_same: assert property (
    land_v[1] |=> mag_q[1] == $past(f_data[MAG_W-1:0]) && dr_q[1])
    else $error("data and flag disagree");
  chk_mag_bytes: assert property (
    rd_en && rd_addr == ADDR_Z_LO |=> rd_data == $past(mag_q[2][7:0]))
    else $error("z low byte wrong");
  chk_decim_hold: assert property (
    acc_valid && dec_cnt_q < dec_lim
    |=> acc_dec_x_q == $past(acc_dec_x_q) && dec_cnt_q != 16'h0000)
    else $error("decimation kept a skipped sample");
  chk_align_x: assert property (
    land_v[0] |=> acc_al_x_q == $past(acc_dec_x_q))
    else $error("accel not aligned with x sample");
  cov_full_set: cover property (set_done ##[1:50] all_read);
  cov_overwrite: cover property (set_done && xyzdr_q);
  cov_fifo_full: cover property (samp_valid && !f_in_ready);
  cov_decimate: cover property (acc_valid && dec_lim != 16'h0000);
endmodule
